// ==== rtl/lcdpwr_pkg.sv ====
// Purpose: Constants for the LCD drive power and scan control block.
// Assumes: Registers sit on APB, one 32-bit aligned word each.
// Notes:   Gain tables are in tenths of a unit.
package lcdpwr_pkg;
    localparam logic [7:0] LCDPWR_OFS_POWER    = 8'h00;
    localparam logic [7:0] LCDPWR_OFS_CONTRAST = 8'h04;
    localparam logic [7:0] LCDPWR_OFS_GAIN     = 8'h08;
    localparam logic [7:0] LCDPWR_OFS_SCAN     = 8'h0c;
    localparam logic [7:0] LCDPWR_OFS_REVERSAL = 8'h10;
    localparam logic [7:0] LCDPWR_OFS_STATUS   = 8'h14;
    localparam int LCDPWR_BIT_PUMP     = 2;
    localparam int LCDPWR_BIT_REG      = 1;
    localparam int LCDPWR_BIT_FOLLOW   = 0;
    localparam int LCDPWR_BIT_SCAN_REV = 0;
    localparam logic [2:0] LCDPWR_RST_POWER    = 3'h0;
    localparam logic [5:0] LCDPWR_RST_CONTRAST = 6'h20;
    localparam logic [2:0] LCDPWR_RST_GAIN     = 3'h0;
    localparam logic [5:0] LCDPWR_RST_REVERSAL = 6'h00;
    localparam logic [5:0] LCDPWR_COEF_MAX     = 6'h3f;
    localparam logic [5:0] LCDPWR_LAST_64      = 6'h3f;
    localparam logic [5:0] LCDPWR_LAST_32      = 6'h1f;
    localparam logic [5:0] LCDPWR_LAST_16      = 6'h0f;
    localparam logic [1:0] LCDPWR_VAR_64       = 2'h0;
    localparam logic [1:0] LCDPWR_VAR_32       = 2'h1;
    localparam logic [1:0] LCDPWR_VAR_16       = 2'h2;
    // Select code to gain in tenths: large panel then small panels.
    localparam logic [7:0] LCDPWR_GAIN_LG [8] = '{8'h2d, 8'h32, 8'h37,
        8'h3c, 8'h41, 8'h46, 8'h4c, 8'h51};
    localparam logic [7:0] LCDPWR_GAIN_SM [8] = '{8'h1e, 8'h23, 8'h28,
        8'h2d, 8'h32, 8'h37, 8'h3c, 8'h41};
    // Drive level encodings of the four levels.
    localparam logic [1:0] LCDPWR_LVL_A = 2'h0;
    localparam logic [1:0] LCDPWR_LVL_B = 2'h1;
    localparam logic [1:0] LCDPWR_LVL_C = 2'h2;
    localparam logic [1:0] LCDPWR_LVL_D = 2'h3;
    typedef enum logic [1:0] {
        LCDPWR_IDLE   = 2'b00,
        LCDPWR_ACCESS = 2'b01
    } lcdpwr_apb_t;
endpackage : lcdpwr_pkg

// ==== rtl/lcdpwr_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input is asynchronous to i_clock.
// Notes:   Output changes only when stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module lcdpwr_sync (
    input  wire logic i_clock,  // Clock.
    input  wire logic i_nrst,   // Async reset, active low.
    input  wire logic i_async,  // Asynchronous level.
    output var  logic o_level   // Filtered level.
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_level <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            o_level <= s3_reg;
        end
    end
endmodule : lcdpwr_sync
`default_nettype wire

// ==== rtl/lcdpwr_scan.sv ====
// Purpose: Common scan index, frame polarity and drive level select.
// Assumes: i_line_step pulses once per scanned line.
// Notes:   A reversal setting of zero gives two-frame alternation.
`timescale 1ns/10ps
`default_nettype none
module lcdpwr_scan
    import lcdpwr_pkg::*;
(
    input  wire logic       i_clock,     // Clock.
    input  wire logic       i_nrst,      // Async reset, active low.
    input  wire logic       i_line_step, // One-cycle line advance.
    input  wire logic [1:0] i_variant,   // Line count variant.
    input  wire logic       i_reverse,   // Scan reversed.
    input  wire logic [5:0] i_nline,     // Reversal setting, n-1.
    input  wire logic       i_pixel,     // Display data bit.
    output var  logic [5:0] o_common,    // Common output index.
    output var  logic       o_polarity,  // Frame polarity signal.
    output var  logic [1:0] o_level      // Drive level select.
);
    logic [5:0] pos_reg;
    logic [5:0] line_cnt_reg;
    logic [5:0] last;
    logic       frame_end;
    logic       line_sel;
    always_comb begin
        unique case (i_variant)
            LCDPWR_VAR_32: last = LCDPWR_LAST_32;
            LCDPWR_VAR_16: last = LCDPWR_LAST_16;
            default:       last = LCDPWR_LAST_64;
        endcase
    end
    assign frame_end = (pos_reg >= last);
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pos_reg <= 6'h00;
        end else if (i_line_step) begin
            pos_reg <= frame_end ? 6'h00 : pos_reg + 6'h01;
        end
    end
    // Index runs ascending or descending from the same position count.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_common <= 6'h00;
        end else begin
            o_common <= i_reverse ? last - pos_reg : pos_reg;
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            line_cnt_reg <= 6'h00;
            o_polarity   <= 1'b0;
        end else if (i_line_step) begin
            if (i_nline == 6'h00) begin
                line_cnt_reg <= 6'h00;
                if (frame_end) begin
                    o_polarity <= ~o_polarity;
                end
            end else if (line_cnt_reg >= i_nline) begin
                line_cnt_reg <= 6'h00;
                o_polarity   <= ~o_polarity;
            end else begin
                line_cnt_reg <= line_cnt_reg + 6'h01;
            end
        end
    end
    assign line_sel = 1'b1;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_level <= LCDPWR_LVL_A;
        end else begin
            unique case ({i_pixel, line_sel, o_polarity})
                3'b000, 3'b010: o_level <= LCDPWR_LVL_A;
                3'b001, 3'b011: o_level <= LCDPWR_LVL_B;
                3'b100, 3'b110: o_level <= LCDPWR_LVL_C;
                default:        o_level <= LCDPWR_LVL_D;
            endcase
        end
    end
endmodule : lcdpwr_scan
`default_nettype wire

// ==== rtl/lcdpwr_top.sv ====
// Purpose: APB register file and drive power control outputs.
// Assumes: APB master holds requests until pready; pready always high.
// Notes:   Enables are gated off while the device is a slave.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module lcdpwr_top
    import lcdpwr_pkg::*;
(
    input  wire logic        i_clock,     // 25 MHz clock.
    input  wire logic        i_nrst,      // Async reset, active low.
    input  wire logic        i_psel,      // APB select.
    input  wire logic        i_penable,   // APB enable.
    input  wire logic        i_pwrite,    // APB write.
    input  wire logic [7:0]  i_paddr,     // APB byte address.
    input  wire logic [31:0] i_pwdata,    // APB write data.
    output var  logic [31:0] o_prdata,    // APB read data.
    output var  logic        o_pready,    // APB ready.
    output var  logic        o_pslverr,   // APB error.
    input  wire logic        i_master,    // Master strap pin.
    input  wire logic [1:0]  i_variant,   // Line count variant.
    input  wire logic        i_line_step, // Line advance pulse.
    input  wire logic        i_pixel,     // Display data bit.
    output var  logic        o_pump_en,   // Charge pump enable.
    output var  logic        o_reg_en,    // Regulator enable.
    output var  logic        o_follow_en, // Follower enable.
    output var  logic [5:0]  o_coef,      // Regulator coefficient.
    output var  logic [2:0]  o_gain_sel,  // Regulator gain select.
    output var  logic [7:0]  o_gain_x10,  // Nominal gain, tenths.
    output var  logic [5:0]  o_common,    // Common output index.
    output var  logic        o_polarity,  // Frame polarity signal.
    output var  logic [1:0]  o_level      // Drive level select.
);
    logic [2:0] power_stage_enables_reg;
    logic [5:0] contrast_level_reg;
    logic [2:0] regulator_gain_select_reg;
    logic       scan_reverse_reg;
    logic [5:0] line_reversal_reg;
    logic       master_level;
    logic       wr_en;
    logic       rd_en;
    logic       mapped;

    function automatic logic ofs_known(input logic [7:0] a);
        return a == LCDPWR_OFS_POWER || a == LCDPWR_OFS_CONTRAST ||
               a == LCDPWR_OFS_GAIN || a == LCDPWR_OFS_SCAN ||
               a == LCDPWR_OFS_REVERSAL || a == LCDPWR_OFS_STATUS;
    endfunction : ofs_known

    lcdpwr_sync u_master_sync (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_async (i_master),
        .o_level (master_level)
    );

    assign mapped = ofs_known(i_paddr);
    // Zero wait states: the access phase completes on its first edge.
    assign wr_en = i_psel && i_penable && i_pwrite && mapped;
    assign rd_en = i_psel && !i_penable && !i_pwrite;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready  <= 1'b1;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= 1'b1;
            o_pslverr <= i_psel && !i_penable && !mapped;
        end
    end

    // Each enable bit is stored separately; no pattern is rejected.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            power_stage_enables_reg <= LCDPWR_RST_POWER;
        end else if (wr_en && i_paddr == LCDPWR_OFS_POWER) begin
            power_stage_enables_reg <= i_pwdata[2:0];
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            contrast_level_reg <= LCDPWR_RST_CONTRAST;
        end else if (wr_en && i_paddr == LCDPWR_OFS_CONTRAST) begin
            contrast_level_reg <= i_pwdata[5:0];
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            regulator_gain_select_reg <= LCDPWR_RST_GAIN;
        end else if (wr_en && i_paddr == LCDPWR_OFS_GAIN) begin
            regulator_gain_select_reg <= i_pwdata[2:0];
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            scan_reverse_reg  <= 1'b0;
            line_reversal_reg <= LCDPWR_RST_REVERSAL;
        end else if (wr_en) begin
            if (i_paddr == LCDPWR_OFS_SCAN) begin
                scan_reverse_reg <= i_pwdata[LCDPWR_BIT_SCAN_REV];
            end
            if (i_paddr == LCDPWR_OFS_REVERSAL) begin
                line_reversal_reg <= i_pwdata[5:0];
            end
        end
    end

    // Outputs follow the registers on the edge after the write.
    // Gating on master mode means a slave never runs its generator.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pump_en   <= 1'b0;
            o_reg_en    <= 1'b0;
            o_follow_en <= 1'b0;
            o_coef      <= LCDPWR_COEF_MAX;
            o_gain_sel  <= LCDPWR_RST_GAIN;
            o_gain_x10  <= LCDPWR_GAIN_LG[0];
        end else begin
            o_pump_en   <= master_level &&
                power_stage_enables_reg[LCDPWR_BIT_PUMP];
            o_reg_en    <= master_level &&
                power_stage_enables_reg[LCDPWR_BIT_REG];
            o_follow_en <= master_level &&
                power_stage_enables_reg[LCDPWR_BIT_FOLLOW];
            o_coef      <= LCDPWR_COEF_MAX - contrast_level_reg;
            o_gain_sel  <= regulator_gain_select_reg;
            o_gain_x10  <= (i_variant == LCDPWR_VAR_64) ?
                LCDPWR_GAIN_LG[regulator_gain_select_reg] :
                LCDPWR_GAIN_SM[regulator_gain_select_reg];
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (i_paddr)
                LCDPWR_OFS_SCAN:
                    o_prdata <= {31'h0, scan_reverse_reg};
                LCDPWR_OFS_REVERSAL:
                    o_prdata <= {26'h0, line_reversal_reg};
                LCDPWR_OFS_STATUS:
                    o_prdata <= {16'h0, o_common, o_level, o_polarity,
                                 master_level, 3'h0, o_pump_en,
                                 o_reg_en, o_follow_en};
                default:
                    o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    lcdpwr_scan u_scan (
        .i_clock     (i_clock),
        .i_nrst      (i_nrst),
        .i_line_step (i_line_step),
        .i_variant   (i_variant),
        .i_reverse   (scan_reverse_reg),
        .i_nline     (line_reversal_reg),
        .i_pixel     (i_pixel),
        .o_common    (o_common),
        .o_polarity  (o_polarity),
        .o_level     (o_level)
    );
endmodule : lcdpwr_top
`default_nettype wire

// ==== tb/lcdpwr_top_properties.sv ====
// Purpose: Concurrent checks on the drive power block's ports.
// Assumes: Register writes reach the outputs within two edges.
// Notes:   Strap waits cover the three-flop master synchroniser.
`timescale 1ns/10ps
`default_nettype none
module lcdpwr_top_properties (
    input wire logic        i_clock,     // Clock.
    input wire logic        i_nrst,      // Reset, active low.
    input wire logic        i_psel,      // APB select.
    input wire logic        i_penable,   // APB enable.
    input wire logic        i_pwrite,    // APB write.
    input wire logic [7:0]  i_paddr,     // APB address.
    input wire logic [31:0] i_pwdata,    // APB write data.
    input wire logic        i_master,    // Master strap.
    input wire logic [1:0]  i_variant,   // Line variant.
    input wire logic        i_line_step, // Line advance.
    input wire logic        i_pixel,     // Data bit.
    input wire logic        o_pump_en,   // Pump enable.
    input wire logic        o_reg_en,    // Regulator enable.
    input wire logic        o_follow_en, // Follower enable.
    input wire logic [5:0]  o_coef,      // Coefficient.
    input wire logic [2:0]  o_gain_sel,  // Gain select.
    input wire logic [7:0]  o_gain_x10,  // Gain, tenths.
    input wire logic [5:0]  o_common,    // Common index.
    input wire logic        o_polarity,  // Frame polarity.
    input wire logic [1:0]  o_level      // Drive level.
);
    wire wr = i_psel && i_penable && i_pwrite;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    coef_map_a: assert property (wr && i_paddr == 8'h04 |-> ##2
        o_coef == 6'h3f - $past(i_pwdata[5:0], 2)) else $error("coef");
    gain_sel_a: assert property (wr && i_paddr == 8'h08 |-> ##2
        o_gain_sel == $past(i_pwdata[2:0], 2)) else $error("gain sel");
    gain_top_a: assert property (
        (i_variant == 2'h0 && o_gain_sel == 3'h7)[*2] |->
        o_gain_x10 == 8'h51) else $error("gain value");
    power_en_a: assert property (
        i_master[*6] ##0 (wr && i_paddr == 8'h00) |-> ##2
        {o_pump_en, o_reg_en, o_follow_en} == $past(i_pwdata[2:0], 2))
        else $error("enables");
    slave_off_a: assert property ((!i_master)[*8] |->
        !(o_pump_en || o_reg_en || o_follow_en)) else $error("slave");
    scan_hold_a: assert property (
        (!i_line_step && !i_psel && $stable(i_variant))[*2] |=>
        $stable(o_common)) else $error("common moved");
    level_map_a: assert property (
        ($stable(i_pixel) && $stable(o_polarity))[*3] |->
        o_level == {i_pixel, o_polarity}) else $error("level");
    pol_hold_a: assert property ((!i_line_step)[*2] |=>
        o_polarity == $past(o_polarity)) else $error("polarity");
    cover property (wr && i_paddr == 8'h04);
    cover property (i_line_step && o_polarity);
    cover property ((!i_master)[*8]);
endmodule : lcdpwr_top_properties
bind lcdpwr_top lcdpwr_top_properties lcdpwr_top_properties_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_master(i_master), .i_variant(i_variant),
    .i_line_step(i_line_step), .i_pixel(i_pixel), .o_pump_en(o_pump_en),
    .o_reg_en(o_reg_en), .o_follow_en(o_follow_en), .o_coef(o_coef),
    .o_gain_sel(o_gain_sel), .o_gain_x10(o_gain_x10),
    .o_common(o_common), .o_polarity(o_polarity), .o_level(o_level));
`default_nettype wire

// ==== tb/lcdpwr_host.sv ====
// Purpose: Host model issuing APB configuration commands.
// Assumes: One transfer at a time; the slave answers via pready.
// Notes:   A released address shows its inverse, never the old value.
`timescale 1ns/10ps
`default_nettype none
module lcdpwr_host (
    input  wire logic        i_clock,   // Clock.
    input  wire logic [31:0] i_prdata,  // Read data.
    input  wire logic        i_pready,  // Ready.
    input  wire logic        i_pslverr, // Error.
    output var  logic        o_psel,    // Select.
    output var  logic        o_penable, // Enable.
    output var  logic        o_pwrite,  // Direction.
    output var  logic [7:0]  o_paddr,   // Address.
    output var  logic [31:0] o_pwdata   // Write data.
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'hff;
        o_pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clock);
        o_penable <= 1'b1;
        do @(posedge i_clock); while (i_pready !== 1'b1);
        q = i_prdata;
        err = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        o_paddr <= ~a;
    endtask : xfer
endmodule : lcdpwr_host
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the drive power control block.
// Assumes: Host model drives APB; outputs settle two edges later.
// Notes:   Only the 32-line variant is scanned, to keep runs short.
`timescale 1ns/10ps
`default_nettype none
module testbench import lcdpwr_pkg::*; ;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        mst = 1'b1;
    logic [1:0]  vari = 2'h1;
    logic        ls = 1'b0;
    logic        pix = 1'b0;
    logic        psel, pen, pwr, prdy, perr, pu, rg, fo, pol, e, p0;
    logic [7:0]  pa, gx;
    logic [31:0] pwd, prd, q;
    logic [5:0]  coef, common_output, c0;
    logic [2:0]  gs;
    logic [1:0]  lvl;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          k, t;
    always #20 clk = ~clk;
    lcdpwr_host lcdpwr_host_inst (.i_clock(clk), .i_prdata(prd),
        .i_pready(prdy), .i_pslverr(perr), .o_psel(psel),
        .o_penable(pen), .o_pwrite(pwr), .o_paddr(pa), .o_pwdata(pwd));
    lcdpwr_top lcdpwr_top_inst (.i_clock(clk), .i_nrst(nrst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
        .o_pslverr(perr), .i_master(mst), .i_variant(vari),
        .i_line_step(ls), .i_pixel(pix), .o_pump_en(pu), .o_reg_en(rg),
        .o_follow_en(fo), .o_coef(coef), .o_gain_sel(gs),
        .o_gain_x10(gx), .o_common(common_output), .o_polarity(pol), .o_level(lvl));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] s, x);
        n_tests++;
        if (s !== x) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        lcdpwr_host_inst.xfer(1'b1, a, d, q, e);
        tick(2);
    endtask : wr
    task automatic step;
        @(posedge clk) ls <= 1'b1;
        @(posedge clk) ls <= 1'b0;
        tick(2);
    endtask : step
    task automatic give_verdict;
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        tick(2);
        chk("coef rst", coef, 32'h1f);
        chk("ready", prdy, 32'h1);
        for (k = 0; k < 8; k++) begin
            wr(LCDPWR_OFS_POWER, k);
            chk("enables", {pu, rg, fo}, k);
        end
        lcdpwr_host_inst.xfer(1'b0, LCDPWR_OFS_STATUS, 0, q, e);
        chk("status", q[6:0], 32'h47);
        lcdpwr_host_inst.xfer(1'b0, LCDPWR_OFS_POWER, 0, q, e);
        chk("wo read", q, 32'h0);
        lcdpwr_host_inst.xfer(1'b0, 8'h18, 0, q, e);
        chk("unmapped", q, 32'h0);
        chk("slverr", e, 32'h1);
        @(posedge clk) mst <= 1'b0;
        tick(10);
        chk("slave", {pu, rg, fo}, 32'h0);
        @(posedge clk) mst <= 1'b1;
        tick(10);
        chk("master", {pu, rg, fo}, 32'h7);
        for (k = 0; k < 2; k++) begin
            wr(LCDPWR_OFS_SCAN, k);
            lcdpwr_host_inst.xfer(1'b0, LCDPWR_OFS_SCAN, 0, q, e);
            chk("scan rd", q, k);
            step();
            repeat (33) begin
                c0 = common_output;
                step();
                chk("common", common_output, (k ? c0 - 1 : c0 + 1) & 6'h1f);
            end
        end
        // Polarity every five lines means four flips in twenty lines.
        wr(LCDPWR_OFS_REVERSAL, 4);
        lcdpwr_host_inst.xfer(1'b0, LCDPWR_OFS_REVERSAL, 0, q, e);
        chk("nline rd", q, 32'h4);
        t = 0;
        repeat (20) begin
            p0 = pol;
            step();
            t += (pol !== p0);
        end
        chk("flips", t, 4);
        for (k = 0; k < 2; k++) begin
            @(posedge clk) pix <= k[0];
            tick(3);
            chk("level", lvl, {k[0], pol});
        end
        wr(LCDPWR_OFS_POWER, 3);
        for (k = 0; k < 4; k++) begin
            wr(LCDPWR_OFS_CONTRAST, k[1] ? 60 + k : k);
            chk("coef", coef, 63 - (k[1] ? 60 + k : k));
        end
        for (k = 0; k < 16; k++) begin
            @(posedge clk) vari <= k[3] ? 2'h2 : 2'h0;
            wr(LCDPWR_OFS_GAIN, k[2:0]);
            chk("gain sel", gs, k[2:0]);
            chk("gain", gx, k[3] ? 30 + 5 * k[2:0] :
                45 + 5 * k[2:0] + (k[2:0] > 5));
        end
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
